/* hw/bqc_pkg.sv */
// constants shared by the bi-quinary counter files
package bqc_pkg;
  // positions of the four counter bits in the state vector
  localparam int unsigned BQC_BIT_BIN = 0;
  localparam int unsigned BQC_BIT_LOW = 1;
  localparam int unsigned BQC_BIT_MID = 2;
  localparam int unsigned BQC_BIT_HIGH = 3;
  localparam int unsigned BQC_NUM_BITS = 4;
  localparam int unsigned BQC_NUM_CLOCKS = 2;
  // stage clock indices for the edge detectors
  localparam int unsigned BQC_CLK_BIN = 0;
  localparam int unsigned BQC_CLK_QUIN = 1;
  // values after srst_i
  localparam logic [3:0] BQC_BITS_RESET = 4'h0;
  localparam logic BQC_PREV_CLK_RESET = 1'b1;
  // quinary stage codes, {high, mid, low}
  localparam logic [2:0] BQC_QUIN_ZERO = 3'h0;
  localparam logic [2:0] BQC_QUIN_THREE = 3'h3;
  localparam logic [2:0] BQC_QUIN_FOUR = 3'h4;
  typedef logic [3:0] bqc_bits_t;
endpackage

/* hw/bqc_edge_det.sv */
// rising-edge detector for one stage clock input
`timescale 1ns/1ns
module bqc_edge_det (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic level_i,
  output logic rise_o
);
  import bqc_pkg::*;

  typedef struct packed {
    logic prev;
  } bqc_edge_state_t;

  bqc_edge_state_t st;
  bqc_edge_state_t next_st;

  // remember the last level seen
  always_comb begin
    next_st = st;
    next_st.prev = level_i;
  end

  // prev resets high so a clock already high at release is not a phantom edge
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st.prev <= BQC_PREV_CLK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // only low-to-high counts; level and falling edge are ignored
  assign rise_o = level_i & ~st.prev;
endmodule

/* hw/bqc_counter.sv */
// bi-quinary counter: divide-by-two stage plus divide-by-five stage
`timescale 1ns/1ns
module bqc_counter (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic binary_stage_clock_i,
  input wire logic quinary_stage_clock_i,
  input wire logic set_binary_i,
  input wire logic set_quin_low_i,
  input wire logic set_quin_mid_i,
  input wire logic set_quin_high_i,
  input wire logic count_clear_i,
  output logic binary_stage_out_o,
  output logic quinary_low_bit_o,
  output logic quinary_mid_bit_o,
  output logic quinary_high_bit_o,
  output logic binary_stage_out_n_o,
  output logic quinary_high_bit_n_o
);
  import bqc_pkg::*;

  typedef struct packed {
    bqc_bits_t bits;
  } bqc_state_t;

  bqc_state_t st;
  bqc_state_t next_st;
  logic [BQC_NUM_CLOCKS-1:0] clk_level;
  logic [BQC_NUM_CLOCKS-1:0] clk_rise;
  bqc_bits_t set_vec;
  bqc_bits_t adv_vec;
  bqc_bits_t next_bits;
  logic [2:0] quin;
  logic [2:0] quin_next;
  logic any_ctl;

  ////////////////////////////////////////////////////////////////////////////
  // stage clock edge detection

  assign clk_level[BQC_CLK_BIN] = binary_stage_clock_i;
  assign clk_level[BQC_CLK_QUIN] = quinary_stage_clock_i;

  // one detector per stage clock; the stages never share an edge
  genvar gc;
  generate
    for (gc = 0; gc < BQC_NUM_CLOCKS; gc++) begin : g_clk
      bqc_edge_det u_edge (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .level_i(clk_level[gc]),
        .rise_o(clk_rise[gc])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // count sequences of the two stages

  assign quin = {st.bits[BQC_BIT_HIGH], st.bits[BQC_BIT_MID], st.bits[BQC_BIT_LOW]};

  // mod-5: low/mid form a 2-bit up count, high marks four, then wrap
  always_comb begin
    if (quin[2]) begin
      quin_next = BQC_QUIN_ZERO;
    end else if (quin == BQC_QUIN_THREE) begin
      quin_next = BQC_QUIN_FOUR;
    end else begin
      quin_next = {1'b0, quin[1:0] + 2'h1};
    end
  end

  // advanced value per bit; stages are independent so any cascade is board wiring
  assign adv_vec[BQC_BIT_BIN] = ~st.bits[BQC_BIT_BIN];
  assign adv_vec[BQC_BIT_LOW] = quin_next[0];
  assign adv_vec[BQC_BIT_MID] = quin_next[1];
  assign adv_vec[BQC_BIT_HIGH] = quin_next[2];

  assign set_vec[BQC_BIT_BIN] = set_binary_i;
  assign set_vec[BQC_BIT_LOW] = set_quin_low_i;
  assign set_vec[BQC_BIT_MID] = set_quin_mid_i;
  assign set_vec[BQC_BIT_HIGH] = set_quin_high_i;

  ////////////////////////////////////////////////////////////////////////////
  // per-bit master-slave cell: set, then clear, then stage edge, then hold

  genvar gb;
  generate
    for (gb = 0; gb < BQC_NUM_BITS; gb++) begin : g_bit
      logic step;
      assign step = (gb == BQC_BIT_BIN) ? clk_rise[BQC_CLK_BIN] : clk_rise[BQC_CLK_QUIN];
      // set wins over clear when both arrive; the board should not do that
      assign next_bits[gb] = set_vec[gb] ? 1'b1 :
                             count_clear_i ? 1'b0 :
                             step ? adv_vec[gb] : st.bits[gb];
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.bits = next_bits;
  end

  // the single state register; overrides land at the next ref_clk_i edge
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st.bits <= BQC_BITS_RESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state flip-flops

  assign binary_stage_out_o = st.bits[BQC_BIT_BIN];
  assign quinary_low_bit_o = st.bits[BQC_BIT_LOW];
  assign quinary_mid_bit_o = st.bits[BQC_BIT_MID];
  assign quinary_high_bit_o = st.bits[BQC_BIT_HIGH];
  assign binary_stage_out_n_o = ~st.bits[BQC_BIT_BIN];
  assign quinary_high_bit_n_o = ~st.bits[BQC_BIT_HIGH];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  assign any_ctl = (|set_vec) | count_clear_i;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_quiet;
    !any_ctl;
  endsequence

  sequence s_quin_step;
    s_quiet ##0 clk_rise[BQC_CLK_QUIN] && !clk_rise[BQC_CLK_BIN];
  endsequence

  a_bin_toggle: assert property (s_quiet ##0 clk_rise[BQC_CLK_BIN] |=>
    binary_stage_out_o != $past(binary_stage_out_o)) else $error("binary stage did not toggle");
  a_hold_no_edge: assert property (s_quiet ##0 clk_rise == 2'h0 |=> $stable(st.bits))
    else $error("bits changed without a rising edge");
  a_clear_all: assert property (count_clear_i && set_vec == 4'h0 |=> st.bits == 4'h0)
    else $error("common clear did not zero all bits");
  a_set_bin: assert property (set_binary_i ##1 set_binary_i |-> binary_stage_out_o)
    else $error("binary set not applied");
  a_set_high: assert property (set_quin_high_i |=> quinary_high_bit_o && !quinary_high_bit_n_o)
    else $error("high bit set not applied");
  a_inv_outs: assert property (binary_stage_out_n_o == !binary_stage_out_o &&
    quinary_high_bit_n_o == !quinary_high_bit_o) else $error("inverted outputs wrong");
  a_quin_three: assert property (s_quin_step ##0 quin == 3'h3 |=> quin == 3'h4 &&
    $stable(binary_stage_out_o)) else $error("quinary 3 did not go to 4");
  a_quin_wrap: assert property (s_quin_step ##0 quin[2] |=> quin == 3'h0)
    else $error("quinary did not wrap after four");
  a_quin_legal: assert property (s_quiet ##1 s_quiet [*2] |-> quin <= 3'h4 || $past(quin) > 3'h4)
    else $error("quinary entered illegal code by counting");

  ////////////////////////////////////////////////////////////////////////////
  // pin-level edge handling, stage independence and per-bit overrides
  // these watch the stage clock pins, not only the detector outputs,
  // so a broken edge detector cannot hide behind its own clk_rise

  // a stage clock pin seen high while nothing overrides the bits
  sequence s_qclk_high;
    s_quiet ##0 quinary_stage_clock_i;
  endsequence

  sequence s_bclk_high;
    s_quiet ##0 binary_stage_clock_i;
  endsequence

  // a stage clock pin low, then high one cycle later, with no override
  sequence s_qclk_rise;
    s_quiet ##0 !quinary_stage_clock_i ##1 s_quiet ##0 quinary_stage_clock_i;
  endsequence

  sequence s_bclk_rise;
    s_quiet ##0 !binary_stage_clock_i ##1 s_quiet ##0 binary_stage_clock_i;
  endsequence

  // edge memory starts high, so a clock already high at release is no edge
  a_release_no_edge: assert property ($fell(srst_i) |-> clk_rise == 2'h0)
    else $error("stage edge seen at reset release");

  // a pin that stays high, or falls, must not count a second time
  a_quin_level_hold: assert property (s_qclk_high ##1 s_quiet |=> $stable(quin))
    else $error("quinary stage moved without a rising edge");
  a_bin_level_hold: assert property (s_bclk_high ##1 s_quiet |=> $stable(binary_stage_out_o))
    else $error("binary stage moved without a rising edge");

  // a clean low-to-high on the pin toggles the binary stage and moves a quinary code below three up by exactly one step
  a_quin_pin_step: assert property (s_qclk_rise ##0 quin < BQC_QUIN_THREE |=> quin == $past(quin) + 3'h1)
    else $error("quinary stage did not step by one");
  a_bin_pin_step: assert property (s_bclk_rise |=> binary_stage_out_o != $past(binary_stage_out_o))
    else $error("binary stage did not toggle on pin edge");

  // stages share no internal path; any cascade is board wiring,
  // so an edge on one stage clock leaves the other stage alone
  a_quin_keeps_bin: assert property (s_quin_step |=> $stable(binary_stage_out_o))
    else $error("quinary edge disturbed binary stage");
  a_bin_keeps_quin: assert property (s_quiet ##0 clk_rise[BQC_CLK_BIN] && !clk_rise[BQC_CLK_QUIN] |=>
    $stable(quin)) else $error("binary edge disturbed quinary stage");

  // clear still wins over a stage edge arriving in the same cycle
  a_clear_beats_edge: assert property (count_clear_i && set_vec == 4'h0 && clk_rise != 2'h0 |=>
    st.bits == BQC_BITS_RESET) else $error("stage edge beat the common clear");

  // each set lands on the next edge, whatever the stage clocks do;
  // limitation: overrides act at the next ref_clk_i edge, not at once
  a_set_low: assert property (set_quin_low_i |=> quinary_low_bit_o)
    else $error("low bit set not applied");
  a_set_mid: assert property (set_quin_mid_i |=> quinary_mid_bit_o)
    else $error("mid bit set not applied");
endmodule

/* testbench/tb_bqc_counter.sv */
// self-checking bench for the bi-quinary counter
`timescale 1ns/1ns
module tb_bqc_counter;
  import bqc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic bclk = 1'b0;
  logic qclk = 1'b0;
  logic clr = 1'b0;
  logic [3:0] set_bits = 4'h0;
  logic [1:0] mode = 2'h0;
  logic bin_o, low_o, mid_o, high_o, bin_n_o, high_n_o;
  int miscompares = 0;
  int cmp_count = 0;
  wire logic [3:0] val = {high_o, mid_o, low_o, bin_o};
  always #50 ref_clk_i = ~ref_clk_i;
  // mode 1 wires the bcd cascade, mode 2 the bi-quinary one
  bqc_counter uut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .binary_stage_clock_i(mode == 2'h2 ? high_n_o : bclk),
    .quinary_stage_clock_i(mode == 2'h1 ? bin_n_o : qclk),
    .set_binary_i(set_bits[0]), .set_quin_low_i(set_bits[1]),
    .set_quin_mid_i(set_bits[2]), .set_quin_high_i(set_bits[3]),
    .count_clear_i(clr), .binary_stage_out_o(bin_o), .quinary_low_bit_o(low_o),
    .quinary_mid_bit_o(mid_o), .quinary_high_bit_o(high_o),
    .binary_stage_out_n_o(bin_n_o), .quinary_high_bit_n_o(high_n_o)
  );
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // high and low three cycles each, room for cascade latency
  task automatic pulse(input bit quin);
    if (quin) qclk = 1'b1; else bclk = 1'b1;
    cyc(3);
    qclk = 1'b0;
    bclk = 1'b0;
    cyc(3);
  endtask
  // clear while rewiring, so the new feed cannot fake an edge
  task automatic set_mode(input logic [1:0] m);
    mode = m;
    clr = 1'b1;
    cyc(3);
    clr = 1'b0;
    cyc(2);
  endtask
  // sets accumulate: each one must leave the bits set before it alone
  task automatic t_sets;
    logic [3:0] set_exp;
    for (int i = 0; i < 4; i++) begin
      set_exp = 4'((2 << i) - 1);
      set_bits = 4'h1 << i;
      cyc(1);
      set_bits = 4'h0;
      cyc(2);
      check("set bit", val, set_exp);
      check("inv out", {2'h0, high_n_o, bin_n_o}, {2'h0, ~set_exp[3], ~set_exp[0]});
    end
    clr = 1'b1;
    pulse(1'b1);
    check("clear beats clock", val, 4'h0);
    set_bits = 4'hf;
    clr = 1'b0;
    cyc(2);
    set_bits = 4'h0;
    clr = 1'b1;
    cyc(2);
    clr = 1'b0;
    check("common clear", val, 4'h0);
  endtask
  task automatic t_stages;
    set_mode(2'h0);
    for (int k = 1; k <= 10; k++) begin
      pulse(1'b1);
      check("quinary", val, {3'(k % 5), 1'b0});
    end
    for (int k = 1; k <= 3; k++) begin
      pulse(1'b0);
      check("binary toggle", val, {3'h0, 1'(k % 2)});
    end
  endtask
  task automatic t_cascade(input logic [1:0] m);
    int c;
    set_mode(m);
    for (int k = 1; k <= 12; k++) begin
      pulse(m == 2'h2);
      c = k % 10;
      if (m == 2'h1) check("bcd", val, 4'(c));
      else check("bi-quinary", val, {3'(c % 5), 1'(c >= 5)});
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    cyc(20);
    srst_i = 1'b0;
    cyc(2);
    check("after reset", val, BQC_BITS_RESET);
    check("inv after reset", {2'h0, high_n_o, bin_n_o}, 4'h3);
    t_sets();
    t_stages();
    t_cascade(2'h1);
    t_cascade(2'h2);
    tally_and_finish();
  end
endmodule
